// ===== logic/otp_programmer.sv
// Programming and identification controller for a 64K x 16 OTP memory
`timescale 1ns/1ns
`include "otp_prog_defs.svh"
module otp_programmer
	import otp_prog_pkg::*;
#(
	parameter int ADDR_W     = 16,
	parameter int MAX_RETRY  = `MAX_RETRY,
	parameter int PULSE_CYC  = `PULSE_CYC
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	// User commands
	input  wire logic              start_prog,
	input  wire logic              start_ident,
	input  wire logic              ident_word,
	input  wire logic [ADDR_W-1:0] last_addr,
	// Source data lookup, same clock, answered combinationally
	output logic      [ADDR_W-1:0] src_addr,
	input  wire logic [15:0]       src_data,
	// User status
	output logic                   busy,
	output logic                   done,
	output logic                   pass,
	output logic                   fail,
	output logic      [15:0]       ident_data,
	// Supply control
	output logic                   supply_prog,
	output logic                   vpp_prog,
	// Device pins
	output logic      [ADDR_W-1:0] mem_addr,
	output logic                   chip_sel_n,
	output logic                   out_en_n,
	output logic                   program_strobe_n,
	output logic                   id_mode_hv_pin,
	output logic      [15:0]       data_out,
	output logic      [15:0]       data_oe,
	input  wire logic [15:0]       data_in
);
	localparam int TW = 12;
	prog_state_e      state;       // Sequencer state
	logic [3:0]       retries;     // Retry pulses on this word
	logic             second_pass; // Verify/retry pass active
	logic [15:0]      din_meta;    // First sync stage
	logic [15:0]      din_sync;    // Second sync stage
	logic             tmr_load;    // Start timed window
	logic [TW-1:0]    tmr_count;   // Window length
	logic             tmr_done;    // Window elapsed
	logic             at_last;     // Current word is the last

	initial begin
		if (ADDR_W != 16) $error("otp_programmer supports 16 address bits");
		if (PULSE_CYC < 1900 || PULSE_CYC > 2100)
			$error("pulse width outside 95..105 us");
		if (MAX_RETRY < 1 || MAX_RETRY > 15) $error("bad MAX_RETRY");
	end

	pulse_timer #(.WIDTH(TW)) timer (
		.clk     (clk),
		.resetn  (resetn),
		.load    (tmr_load),
		.count   (tmr_count),
		.expired (tmr_done)
	);

	// Read data arrives from pins: two flops before use
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			din_meta <= 16'h0000;
			din_sync <= 16'h0000;
		end else begin
			din_meta <= data_in;
			din_sync <= din_meta;
		end
	end

	assign at_last  = (mem_addr == last_addr);
	assign src_addr = mem_addr;
	assign busy     = (state != st_idle) && (state != st_done);

	// Window lengths per state; timer reloads on entry to each timed state
	always_comb begin
		tmr_load  = 1'b0;
		tmr_count = TW'(`SETUP_CYC);
		case (state)
			st_idle: begin
				tmr_load  = start_prog || start_ident;
				tmr_count = TW'(`SUPPLY_CYC);
			end
			st_pulse_setup: begin
				tmr_load  = tmr_done;
				tmr_count = TW'(PULSE_CYC - 1);
			end
			st_pulse: begin
				tmr_load  = tmr_done;
				tmr_count = TW'(`SETUP_CYC);
			end
			st_pulse_hold: begin
				tmr_load  = tmr_done;
				tmr_count = second_pass ? TW'(`READ_CYC + 2)
					: TW'(`SETUP_CYC);
			end
			st_verify, st_readback: begin
				tmr_load  = tmr_done;
				tmr_count = TW'(`SETUP_CYC);
			end
			st_power_up, st_power_down: begin
				tmr_load  = tmr_done;
				tmr_count = TW'(`SETUP_CYC);
			end
			default: begin
				tmr_load  = 1'b0;
				tmr_count = TW'(`SETUP_CYC);
			end
		endcase
	end

	// Sequencer: two programming passes, then low-voltage readback
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state       <= st_idle;
			mem_addr    <= '0;
			retries     <= 4'h0;
			second_pass <= 1'b0;
			pass        <= 1'b0;
			fail        <= 1'b0;
			ident_data  <= 16'h0000;
		end else begin
			case (state)
				st_idle: begin
					mem_addr    <= '0;
					retries     <= 4'h0;
					second_pass <= 1'b0;
					if (start_prog) begin
						pass  <= 1'b0;
						fail  <= 1'b0;
						state <= st_power_up;
					end else if (start_ident) begin
						// Only the select bit may be high
						mem_addr <= ADDR_W'(ident_word);
						state    <= st_ident;
					end
				end
				st_power_up: begin
					if (tmr_done) state <= st_pulse_setup;
				end
				st_pulse_setup: begin
					if (tmr_done) state <= st_pulse;
				end
				st_pulse: begin
					if (tmr_done) state <= st_pulse_hold;
				end
				st_pulse_hold: begin
					if (tmr_done) begin
						if (second_pass) begin
							state <= st_verify;
						end else if (at_last) begin
							second_pass <= 1'b1;
							mem_addr    <= '0;
							state       <= st_verify;
						end else begin
							// First pass skips verify entirely
							mem_addr <= mem_addr + ADDR_W'(1);
							state    <= st_pulse_setup;
						end
					end
				end
				st_verify: begin
					if (tmr_done) begin
						if (din_sync == src_data) begin
							retries <= 4'h0;
							if (at_last) begin
								mem_addr <= '0;
								state    <= st_power_down;
							end else begin
								mem_addr <= mem_addr + ADDR_W'(1);
							end
						end else if (retries == 4'(MAX_RETRY)) begin
							fail  <= 1'b1;
							state <= st_done;
						end else begin
							retries <= retries + 4'h1;
							state   <= st_pulse_setup;
						end
					end
				end
				st_power_down: begin
					if (tmr_done) state <= st_readback;
				end
				st_readback: begin
					if (tmr_done) begin
						if (din_sync != src_data) begin
							fail  <= 1'b1;
							state <= st_done;
						end else if (at_last) begin
							pass  <= 1'b1;
							state <= st_done;
						end else begin
							mem_addr <= mem_addr + ADDR_W'(1);
						end
					end
				end
				st_ident: begin
					if (tmr_done) begin
						ident_data <= din_sync;
						state      <= st_done;
					end
				end
				st_done: begin
					state <= st_idle;
				end
				default: begin
					state <= st_idle;
				end
			endcase
		end
	end

	assign done = (state == st_done);

	// Supplies high for both programming passes only
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			supply_prog <= 1'b0;
			vpp_prog    <= 1'b0;
		end else begin
			supply_prog <= (state == st_power_up) || (state == st_pulse_setup)
				|| (state == st_pulse) || (state == st_pulse_hold)
				|| (state == st_verify);
			vpp_prog    <= (state == st_power_up) || (state == st_pulse_setup)
				|| (state == st_pulse) || (state == st_pulse_hold)
				|| (state == st_verify);
		end
	end

	// Control pins and data drive per phase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chip_sel_n       <= 1'b1;
			out_en_n         <= 1'b1;
			program_strobe_n <= 1'b1;
			id_mode_hv_pin   <= 1'b0;
			data_out         <= 16'h0000;
			data_oe          <= 16'h0000;
		end else begin
			chip_sel_n       <= (state == st_idle) || (state == st_done)
				|| (state == st_power_up) || (state == st_power_down);
			// Strobe low only in the timed pulse window
			program_strobe_n <= (state != st_pulse);
			// Verify, readback and id read with enable low; device floats
			// its outputs otherwise, so no contention with our drive
			out_en_n         <= !((state == st_verify)
				|| (state == st_readback) || (state == st_ident));
			id_mode_hv_pin   <= (state == st_ident);
			data_out         <= src_data;
			data_oe          <= {16{(state == st_pulse_setup)
				|| (state == st_pulse) || (state == st_pulse_hold)}};
		end
	end
endmodule

// ===== logic/otp_prog_defs.svh
// Timing constants and rule summary for the OTP word programmer
// Function
// - Program pulse 100 us, within 95..105 us
// - Start at word zero, raise supplies first
// - First pass: one pulse per word, no verify
// - Second pass: verify, up to 10 retries
// - Still failing after tenth retry: device failed
// - On verify pass advance until all checked
// - Lower supplies, read back all, compare
// - Id mode: address low, high-voltage pin, toggle select
`ifndef OTP_PROG_DEFS_SVH
`define OTP_PROG_DEFS_SVH
`define CLK_HZ          20000000
`define PULSE_NS        100000
`define PULSE_CYC       ((`PULSE_NS * (`CLK_HZ / 1000000)) / 1000)
`define SETUP_NS        2000
`define SETUP_CYC       ((`SETUP_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define READ_NS         150
`define READ_CYC        ((`READ_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define SUPPLY_NS       2000
`define SUPPLY_CYC      ((`SUPPLY_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define MAX_RETRY       10
`endif

// ===== logic/otp_prog_pkg.sv
// Types shared by the OTP word programmer
package otp_prog_pkg;
	typedef enum logic [3:0] {
		st_idle,
		st_power_up,
		st_pulse_setup,
		st_pulse,
		st_pulse_hold,
		st_verify,
		st_power_down,
		st_readback,
		st_ident,
		st_done
	} prog_state_e;
endpackage

// ===== logic/pulse_timer.sv
// Down counter that times strobe, setup and read windows
`timescale 1ns/1ns
module pulse_timer #(
	parameter int WIDTH = 12
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// Control
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] count,
	// Status
	output logic                  expired
);
	logic [WIDTH-1:0] remain;      // Cycles still to run

	initial begin
		if (WIDTH < 2) $error("pulse_timer WIDTH too small");
	end

	// Load starts a window; expiry is flagged when remain reaches zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			remain <= '0;
		end else if (load) begin
			remain <= count;
		end else if (remain != '0) begin
			remain <= remain - WIDTH'(1);
		end
	end

	// Expiry depends on the count alone: the caller derives load from it,
	// so gating it with load again would close a combinational loop
	assign expired = (remain == '0);
endmodule

// ===== tb/otp_prog_sva.sv
// Checker for the OTP programmer pin sequencing
`timescale 1ns/1ns
module otp_prog_sva #(
	parameter int ADDR_W = 16
) (
	// Clock and reset
	input wire logic              clk,
	input wire logic              resetn,
	// Watched outputs
	input wire logic              busy,
	input wire logic              pass,
	input wire logic              supply_prog,
	input wire logic              vpp_prog,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic              chip_sel_n,
	input wire logic              out_en_n,
	input wire logic              program_strobe_n,
	input wire logic              id_mode_hv_pin,
	input wire logic [15:0]       data_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic [11:0]       lo_cnt; // Low cycles of the strobe
	logic [4:0]        rt_cnt; // Pulses at one address
	logic [ADDR_W-1:0] addr_q; // Address one cycle ago
	sequence pulse_go;
		$fell(program_strobe_n);
	endsequence
	sequence pulse_end;
		$rose(program_strobe_n);
	endsequence
	// Strobe width counter
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) lo_cnt <= '0;
		else if (!program_strobe_n) lo_cnt <= lo_cnt + 12'h001;
		else lo_cnt <= '0;
	end
	// Pulse tally, restarted on a new address or when idle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) rt_cnt <= '0;
		else if (!busy || mem_addr != addr_q) rt_cnt <= '0;
		else if ($rose(program_strobe_n)) rt_cnt <= rt_cnt + 5'h01;
	end
	always_ff @(posedge clk) begin
		addr_q <= mem_addr;
	end
	pulse_width_a: assert property (pulse_end |->
		lo_cnt >= 12'h76C && lo_cnt <= 12'h834) else $error("bad width");
	supply_first_a: assert property (pulse_go |->
		supply_prog && vpp_prog) else $error("pulse unpowered");
	start_addr_a: assert property ($rose(vpp_prog) |->
		mem_addr == '0) else $error("start address");
	pulse_mode_a: assert property (!program_strobe_n |->
		!chip_sel_n && out_en_n && data_oe == 16'hFFFF) else $error("pulse pins");
	verify_mode_a: assert property (!out_en_n |->
		program_strobe_n && !chip_sel_n && data_oe == 16'h0000)
		else $error("read pins");
	retry_bound_a: assert property (rt_cnt <= 5'h0B)
		else $error("too many pulses");
	id_select_a: assert property (id_mode_hv_pin |->
		mem_addr[ADDR_W-1:1] == '0 && !vpp_prog) else $error("id pins");
	supply_off_a: assert property ($rose(pass) |->
		!supply_prog && !vpp_prog) else $error("supplies high");
	pulse_busy_a: assert property (pulse_go |-> busy)
		else $error("idle pulse");
endmodule
bind otp_programmer otp_prog_sva #(.ADDR_W(ADDR_W)) u_sva (
	.clk(clk), .resetn(resetn), .busy(busy), .pass(pass),
	.supply_prog(supply_prog), .vpp_prog(vpp_prog),
	.mem_addr(mem_addr), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
	.program_strobe_n(program_strobe_n),
	.id_mode_hv_pin(id_mode_hv_pin), .data_oe(data_oe));

// ===== tb/otp_dev_model.sv
// Behavioural model of the OTP memory on the pin side
`timescale 1ns/1ns
module otp_dev_model #(
	parameter logic [7:0] MFR = 8'h5A, // Arbitrary value
	parameter logic [7:0] DEV = 8'hC3  // Arbitrary value
) (
	// Device pins
	input wire logic [15:0] mem_addr,
	input wire logic        chip_sel_n,
	input wire logic        out_en_n,
	input wire logic        program_strobe_n,
	input wire logic        id_mode_hv_pin,
	input wire logic [15:0] data_out,
	input wire logic [15:0] data_oe,
	// Slow word and its pulse quota
	input wire logic [1:0]  hard_addr,
	input wire logic [4:0]  hard_need,
	// Resolved data wire
	output logic     [15:0] data_in
);
	logic [15:0] mem [4]; // Word store, erased to ones
	logic [4:0]  cnt [4]; // Pulses seen per word
	logic [15:0] last;    // Last value driven
	logic [15:0] dev_q;   // Device side of the wire
	logic [1:0]  a;       // Decoded word
	logic        drive;
	assign a = mem_addr[1:0];
	initial begin
		last = 16'hFFFF;
		for (int i = 0; i < 4; i++) begin
			mem[i] = 16'hFFFF;
			cnt[i] = 5'h00;
		end
	end
	// The slow word sticks only once its quota is met
	always @(posedge program_strobe_n) begin
		if (!chip_sel_n && out_en_n) begin
			cnt[a] = cnt[a] + 5'h01;
			if (a != hard_addr || cnt[a] >= hard_need) mem[a] = data_in;
		end
	end
	assign drive = !chip_sel_n && !out_en_n && program_strobe_n;
	// Undriven wire shows a changed value, never the stale one
	always @* begin
		if (drive && id_mode_hv_pin) dev_q = {8'h00, a[0] ? DEV : MFR};
		else if (drive) dev_q = mem[a];
		else dev_q = ~last;
	end
	always @(dev_q) if (drive) last = dev_q;
	assign data_in = (data_oe & data_out) | (~data_oe & dev_q);
endmodule

// ===== tb/tb_otp_programmer.sv
// Self-checking testbench for the OTP programmer
`timescale 1ns/1ns
module tb_otp_programmer;
	logic        clk, resetn, start_prog, start_ident, ident_word;
	logic        busy, done, pass, fail, supply_prog, vpp_prog;
	logic        chip_sel_n, out_en_n, program_strobe_n, id_mode_hv_pin;
	logic [15:0] last_addr, src_addr, src_data, ident_data, mem_addr;
	logic [15:0] data_out, data_oe, data_in;
	logic [1:0]  hard_addr;
	logic [4:0]  hard_need;
	int          error_cnt, tests_run;
	assign src_data = 16'h3C5A ^ src_addr; // Source image
	otp_programmer DUT (.clk(clk), .resetn(resetn), .start_prog(start_prog),
		.start_ident(start_ident), .ident_word(ident_word),
		.last_addr(last_addr), .src_addr(src_addr), .src_data(src_data),
		.busy(busy), .done(done), .pass(pass), .fail(fail),
		.ident_data(ident_data), .supply_prog(supply_prog),
		.vpp_prog(vpp_prog), .mem_addr(mem_addr), .chip_sel_n(chip_sel_n),
		.out_en_n(out_en_n), .program_strobe_n(program_strobe_n),
		.id_mode_hv_pin(id_mode_hv_pin), .data_out(data_out),
		.data_oe(data_oe), .data_in(data_in));
	otp_dev_model m (.mem_addr(mem_addr), .chip_sel_n(chip_sel_n),
		.out_en_n(out_en_n), .program_strobe_n(program_strobe_n),
		.id_mode_hv_pin(id_mode_hv_pin), .data_out(data_out),
		.data_oe(data_oe), .hard_addr(hard_addr), .hard_need(hard_need),
		.data_in(data_in));
	always #25 clk = ~clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One command, then a bounded wait for done
	task automatic run(input logic prog);
		int n;
		@(posedge clk);
		#1 start_prog = prog;
		start_ident = !prog;
		@(posedge clk);
		#1 start_prog = 1'b0;
		start_ident = 1'b0;
		chk({15'h0000, busy}, 16'h0001);
		for (n = 0; n < 40000 && done !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		chk({15'h0000, done}, 16'h0001);
		chk({15'h0000, busy}, 16'h0000);
		@(posedge clk);
		#1;
	endtask
	// Word one needs three pulses before it sticks
	task automatic prog_retry();
		hard_addr = 2'h1;
		hard_need = 5'h03;
		last_addr = 16'h0001;
		run(1'b1);
		chk({15'h0000, pass}, 16'h0001);
		chk({15'h0000, fail}, 16'h0000);
		chk(m.mem[1], 16'h3C5B);
		chk({11'h000, m.cnt[1]}, 16'h0003);
		chk({11'h000, m.cnt[0]}, 16'h0001);
	endtask
	// Word two never sticks, so the part is failed
	task automatic prog_dead();
		hard_addr = 2'h2;
		hard_need = 5'h1F;
		last_addr = 16'h0002;
		run(1'b1);
		chk({15'h0000, fail}, 16'h0001);
		chk({15'h0000, pass}, 16'h0000);
		chk({11'h000, m.cnt[2]}, 16'h000B);
		chk({11'h000, m.cnt[0]}, 16'h0002);
	endtask
	// Both identification words
	task automatic ident_read();
		ident_word = 1'b0;
		run(1'b0);
		chk(ident_data, 16'h005A);
		ident_word = 1'b1;
		run(1'b0);
		chk(ident_data, 16'h00C3);
	endtask
	task automatic results();
		if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		{clk, resetn, start_prog, start_ident, ident_word} = 5'h00;
		{hard_addr, hard_need, last_addr} = '0;
		error_cnt = 0;
		tests_run = 0;
		repeat (10) @(posedge clk);
		#1 resetn = 1'b1;
		prog_retry();
		prog_dead();
		ident_read();
		results();
	end
	// Watchdog well past the expected run
	initial begin
		#4000000;
		error_cnt++;
		results();
	end
endmodule
